// ===== shared/fbb_pkg.sv
/*
  fbb_pkg: constants for the fieldbus object to register bridge.
  assumes a single 50 MHz clock domain and 16-bit internal registers.
*/
package fbb_pkg;

  localparam logic [15:0] FBB_INDEX_OFFSET     = 16'h2001;
  localparam int          FBB_INDEX_OFFSET_DEC = 8193;

  localparam logic [15:0] FBB_REG_SINK_POWER   = 16'h01F2;
  localparam logic [15:0] FBB_REG_SINK_CURRENT = 16'h01F3;
  localparam logic [15:0] FBB_REG_VOLTAGE      = 16'h01F4;
  localparam logic [15:0] FBB_REG_CURRENT      = 16'h01F5;
  localparam logic [15:0] FBB_REG_POWER        = 16'h01F6;
  localparam logic [15:0] FBB_REG_RESISTANCE   = 16'h01F7;
  localparam logic [15:0] FBB_REG_SINK_RES     = 16'h01F8;
  localparam logic [15:0] FBB_REG_STATUS       = 16'h01F9;
  localparam logic [15:0] FBB_REG_STATUS_HI    = 16'h01FA;
  localparam logic [15:0] FBB_REG_VMON         = 16'h01FB;
  localparam logic [15:0] FBB_REG_IMON         = 16'h01FC;
  localparam logic [15:0] FBB_REG_REMOTE       = 16'h0192;

  localparam logic [15:0] FBB_REMOTE_ON        = 16'hFF00;
  localparam logic [15:0] FBB_REMOTE_OFF       = 16'h0000;
  localparam logic [15:0] FBB_FULL_SCALE       = 16'hCCCC;
  localparam logic [15:0] FBB_SETPOINT_RESET   = 16'h0000;

  // output image slot numbers
  localparam int FBB_SLOTS     = 7;
  localparam int FBB_SLOT_U    = 0;
  localparam int FBB_SLOT_I    = 1;
  localparam int FBB_SLOT_P    = 2;
  localparam int FBB_SLOT_R    = 3;
  localparam int FBB_SLOT_SI   = 4;
  localparam int FBB_SLOT_SP   = 5;
  localparam int FBB_SLOT_SR   = 6;

  localparam logic [2:0] FBB_SLOT_W = 3'h7;

  typedef enum logic [1:0] {
    FBB_SVC_IDLE  = 2'b00,
    FBB_SVC_WAIT  = 2'b01,
    FBB_SVC_REPLY = 2'b10
  } fbb_svc_state_t;

endpackage

// ===== verilog/fbb_slot.sv
/*
  fbb_slot: one 16-bit set value slot of the cyclic output image.
  assumes the top module decides when a cyclic or service write hits it.
*/
`timescale 1ns/1ps
module fbb_slot
  import fbb_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] value_o
);

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      value_o <= FBB_SETPOINT_RESET;
    end else if (wr_i) begin
      value_o <= wdata_i;
    end
  end

endmodule

// ===== verilog/fbb_bridge.sv
/*
  fbb_bridge: translates cyclic images and acyclic service accesses of a
  fieldbus master into accesses on the internal register space.
  assumes the fieldbus framing layer delivers decoded images and service
  requests as strobes, and the internal register space answers every
  read or write with one done pulse, no earlier than the next cycle.
*/
`timescale 1ns/1ps
// Contract
// - object index is register number plus 8193.
// - register number is object index minus 0x2001.
// - input image carries 32-bit status from register 505.
// - input image carries voltage monitor from register 507.
// - input image carries current monitor from register 508.
// - cyclic voltage, current, power, resistance set values go to 500..503.
// - bidirectional units also map sink set values to 499, 498, 504.
// - resistance set values only act where resistance regulation exists.
// - cyclic output image steers only set values; all else is acyclic.
// - no remapping into the cyclic output image is supported.
// - object accesses become register accesses and answers return translated.
// - service dictionary is served only while online with the fieldbus.
// - scaling: 0xCCCC is 100 per cent, 0x0000 is 0 per cent.
// - remote register: 0xFF00 requests remote control, 0x0000 releases.
module fbb_bridge
  import fbb_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        bidir_i,
  input  wire logic        res_feature_i,
  input  wire logic        online_i,
  input  wire logic        out_img_valid_i,
  input  wire logic [15:0] out_voltage_i,
  input  wire logic [15:0] out_current_i,
  input  wire logic [15:0] out_power_i,
  input  wire logic [15:0] out_resistance_i,
  input  wire logic [15:0] out_sink_current_i,
  input  wire logic [15:0] out_sink_power_i,
  input  wire logic [15:0] out_sink_res_i,
  input  wire logic [31:0] out_control_i,
  input  wire logic [31:0] status_word_i,
  input  wire logic [15:0] voltage_mon_i,
  input  wire logic [15:0] current_mon_i,
  input  wire logic        svc_req_i,
  input  wire logic        svc_write_i,
  input  wire logic [15:0] svc_index_i,
  input  wire logic [15:0] svc_wdata_i,
  input  wire logic        reg_done_i,
  input  wire logic        reg_err_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic             in_img_valid_o,
  output logic      [31:0] in_status_o,
  output logic      [15:0] in_voltage_mon_o,
  output logic      [15:0] in_current_mon_o,
  output logic      [31:0] in_control_o,
  output logic      [15:0] voltage_setpoint_o,
  output logic      [15:0] current_setpoint_o,
  output logic      [15:0] power_setpoint_o,
  output logic      [15:0] resistance_setpoint_o,
  output logic      [15:0] sink_current_setpoint_o,
  output logic      [15:0] sink_power_setpoint_o,
  output logic      [15:0] sink_resistance_setpoint_o,
  output logic             remote_req_o,
  output logic             svc_busy_o,
  output logic             svc_ack_o,
  output logic             svc_err_o,
  output logic      [15:0] svc_index_o,
  output logic      [15:0] svc_rdata_o,
  output logic             reg_req_o,
  output logic             reg_write_o,
  output logic      [15:0] reg_addr_o,
  output logic      [15:0] reg_wdata_o
);

  logic [15:0]    img   [FBB_SLOTS];
  logic [15:0]    cyc_v [FBB_SLOTS];
  logic           slot_wr [FBB_SLOTS];
  logic [15:0]    slot_wd [FBB_SLOTS];
  logic [15:0]    svc_reg;
  logic [2:0]     svc_slot;
  logic           svc_slot_hit;
  logic           slot_ok [FBB_SLOTS];
  fbb_svc_state_t state_q;
  fbb_svc_state_t state_d;
  logic [2:0]     svc_slot_q;
  logic           svc_accept;
  logic           svc_refuse;
  logic           svc_finish;
  logic           svc_wr_ok;
  logic           remote_hit;

  assign cyc_v[FBB_SLOT_U]  = out_voltage_i;
  assign cyc_v[FBB_SLOT_I]  = out_current_i;
  assign cyc_v[FBB_SLOT_P]  = out_power_i;
  assign cyc_v[FBB_SLOT_R]  = out_resistance_i;
  assign cyc_v[FBB_SLOT_SI] = out_sink_current_i;
  assign cyc_v[FBB_SLOT_SP] = out_sink_power_i;
  assign cyc_v[FBB_SLOT_SR] = out_sink_res_i;

  // sink slots only with bidirectional units, resistance only with the feature
  assign slot_ok[FBB_SLOT_U]  = 1'b1;
  assign slot_ok[FBB_SLOT_I]  = 1'b1;
  assign slot_ok[FBB_SLOT_P]  = 1'b1;
  assign slot_ok[FBB_SLOT_R]  = res_feature_i;
  assign slot_ok[FBB_SLOT_SI] = bidir_i;
  assign slot_ok[FBB_SLOT_SP] = bidir_i;
  assign slot_ok[FBB_SLOT_SR] = bidir_i & res_feature_i;

  // index to register number; subtraction is exact in binary
  assign svc_reg = svc_index_i - FBB_INDEX_OFFSET;

  always_comb begin
    svc_slot_hit = 1'b1;
    svc_slot     = FBB_SLOT_W;
    case (svc_reg)
      FBB_REG_VOLTAGE:      svc_slot = 3'(FBB_SLOT_U);
      FBB_REG_CURRENT:      svc_slot = 3'(FBB_SLOT_I);
      FBB_REG_POWER:        svc_slot = 3'(FBB_SLOT_P);
      FBB_REG_RESISTANCE:   svc_slot = 3'(FBB_SLOT_R);
      FBB_REG_SINK_CURRENT: svc_slot = 3'(FBB_SLOT_SI);
      FBB_REG_SINK_POWER:   svc_slot = 3'(FBB_SLOT_SP);
      FBB_REG_SINK_RES:     svc_slot = 3'(FBB_SLOT_SR);
      default:              svc_slot_hit = 1'b0;
    endcase
  end

  // a set value slot is written by the cyclic image or by a service write;
  // cyclic image wins a same-cycle collision since it refreshes every cycle
  for (genvar g = 0; g < FBB_SLOTS; g++) begin : g_slot
    always_comb begin
      slot_wr[g] = 1'b0;
      slot_wd[g] = cyc_v[g];
      if (out_img_valid_i && slot_ok[g]) begin
        slot_wr[g] = 1'b1;
      end else if (svc_wr_ok && svc_slot_q == 3'(g) && slot_ok[g]) begin
        slot_wr[g] = 1'b1;
        slot_wd[g] = reg_wdata_o;
      end
    end
    fbb_slot u_slot (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .wr_i    (slot_wr[g]),
      .wdata_i (slot_wd[g]),
      .value_o (img[g])
    );
  end

  assign voltage_setpoint_o         = img[FBB_SLOT_U];
  assign current_setpoint_o         = img[FBB_SLOT_I];
  assign power_setpoint_o           = img[FBB_SLOT_P];
  assign resistance_setpoint_o      = img[FBB_SLOT_R];
  assign sink_current_setpoint_o    = img[FBB_SLOT_SI];
  assign sink_power_setpoint_o      = img[FBB_SLOT_SP];
  assign sink_resistance_setpoint_o = img[FBB_SLOT_SR];

  // input image refreshed every cycle from live device state
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      in_status_o      <= '0;
      in_voltage_mon_o <= '0;
      in_current_mon_o <= '0;
    end else begin
      in_status_o      <= status_word_i;
      in_voltage_mon_o <= voltage_mon_i;
      in_current_mon_o <= current_mon_i;
    end
  end

  // valid tracks the link state one cycle late, in step with the image
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      in_img_valid_o <= 1'b0;
    end else begin
      in_img_valid_o <= online_i;
    end
  end

  // control object is opaque: carried through untouched, never decoded
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      in_control_o <= '0;
    end else begin
      in_control_o <= out_control_i;
    end
  end

  // service path: one outstanding request, captured fields held for reply;
  // requests while not idle are dropped, the master must wait for the reply
  assign svc_accept = (state_q == FBB_SVC_IDLE) && svc_req_i && online_i;
  assign svc_refuse = (state_q == FBB_SVC_IDLE) && svc_req_i && !online_i;
  assign svc_finish = (state_q == FBB_SVC_WAIT) && reg_done_i;
  assign svc_wr_ok  = svc_finish && !reg_err_i && reg_write_o;
  assign remote_hit = svc_wr_ok && (reg_addr_o == FBB_REG_REMOTE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      FBB_SVC_IDLE: begin
        if (svc_accept) begin
          state_d = FBB_SVC_WAIT;
        end
      end
      FBB_SVC_WAIT: begin
        if (reg_done_i) begin
          state_d = FBB_SVC_REPLY;
        end
      end
      FBB_SVC_REPLY: begin
        state_d = FBB_SVC_IDLE;
      end
      default: begin
        state_d = FBB_SVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q <= FBB_SVC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // one-cycle strobe towards the register space
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      reg_req_o <= 1'b0;
    end else begin
      reg_req_o <= svc_accept;
    end
  end

  // request fields stay put until the next accepted request
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      reg_write_o <= 1'b0;
      reg_addr_o  <= '0;
      reg_wdata_o <= '0;
      svc_slot_q  <= FBB_SLOT_W;
    end else if (svc_accept) begin
      reg_write_o <= svc_write_i;
      reg_addr_o  <= svc_reg;
      reg_wdata_o <= svc_wdata_i;
      svc_slot_q  <= svc_slot_hit ? svc_slot : FBB_SLOT_W;
    end
  end

  // busy covers the wait for the register space and the reply cycle
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      svc_busy_o <= 1'b0;
    end else if (svc_accept) begin
      svc_busy_o <= 1'b1;
    end else if (state_q == FBB_SVC_REPLY) begin
      svc_busy_o <= 1'b0;
    end
  end

  // reply strobes last one cycle each
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      svc_ack_o <= 1'b0;
      svc_err_o <= 1'b0;
    end else begin
      svc_ack_o <= svc_finish && !reg_err_i;
      svc_err_o <= svc_refuse || (svc_finish && reg_err_i);
    end
  end

  // reply with the register number turned back into an object index
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      svc_index_o <= '0;
    end else if (svc_refuse) begin
      svc_index_o <= svc_index_i;
    end else if (svc_finish) begin
      svc_index_o <= reg_addr_o + 16'(FBB_INDEX_OFFSET_DEC);
    end
  end

  // read data stays until the next answer from the register space
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      svc_rdata_o <= '0;
    end else if (svc_finish) begin
      svc_rdata_o <= reg_rdata_i;
    end
  end

  // remote control only via service objects, never cyclic;
  // any other written value leaves the request as it stands
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      remote_req_o <= 1'b0;
    end else if (remote_hit && reg_wdata_o == FBB_REMOTE_ON) begin
      remote_req_o <= 1'b1;
    end else if (remote_hit && reg_wdata_o == FBB_REMOTE_OFF) begin
      remote_req_o <= 1'b0;
    end
  end

  // the cyclic output image has fixed slots and no mapping logic
  // values pass unscaled; full scale FBB_FULL_SCALE is the far side's

endmodule

// ===== verification/fbb_bridge_assertions.sv
/* port checks of fbb_bridge.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module fbb_bridge_assertions
  import fbb_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        bidir_i,
  input wire logic        res_feature_i,
  input wire logic        online_i,
  input wire logic        out_img_valid_i,
  input wire logic [15:0] out_voltage_i,
  input wire logic [31:0] status_word_i,
  input wire logic        svc_req_i,
  input wire logic [15:0] svc_index_i,
  input wire logic        reg_done_i,
  input wire logic        reg_err_i,
  input wire logic [31:0] in_status_o,
  input wire logic [15:0] voltage_setpoint_o,
  input wire logic [15:0] resistance_setpoint_o,
  input wire logic [15:0] sink_current_setpoint_o,
  input wire logic        remote_req_o,
  input wire logic        svc_busy_o,
  input wire logic        svc_ack_o,
  input wire logic        svc_err_o,
  input wire logic [15:0] svc_index_o,
  input wire logic        reg_req_o,
  input wire logic        reg_write_o,
  input wire logic [15:0] reg_addr_o,
  input wire logic [15:0] reg_wdata_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  map_down_a: assert property (svc_req_i && !svc_busy_o && online_i |=> reg_req_o
    && reg_addr_o == $past(svc_index_i) - FBB_INDEX_OFFSET) else $error("bad reg number");
  map_up_a: assert property (svc_ack_o |-> svc_index_o == reg_addr_o + FBB_INDEX_OFFSET)
    else $error("bad reply index");
  offline_err_a: assert property (svc_req_i && !svc_busy_o && !online_i
    |=> svc_err_o && !reg_req_o) else $error("offline request not refused");
  volt_set_a: assert property (out_img_valid_i |=> voltage_setpoint_o == $past(out_voltage_i))
    else $error("voltage set value not taken");
  res_gate_a: assert property (!res_feature_i |=> $stable(resistance_setpoint_o))
    else $error("resistance changed without feature");
  sink_gate_a: assert property (!bidir_i |=> $stable(sink_current_setpoint_o))
    else $error("sink value changed on plain unit");
  status_img_a: assert property ($past(rstn_i) |-> in_status_o == $past(status_word_i))
    else $error("status image wrong");
  remote_set_a: assert property (reg_done_i && !reg_err_i && reg_write_o
    && reg_addr_o == FBB_REG_REMOTE && (reg_wdata_o == FBB_REMOTE_ON || reg_wdata_o ==
    FBB_REMOTE_OFF) |=> remote_req_o == $past(reg_wdata_o[15])) else $error("remote wrong");
endmodule

// ===== verification/fbb_regspace_model.sv
/* internal register space answering the bridge.
   assumes one request at a time with address held until done. */
`timescale 1ns/1ps
module fbb_regspace_model
  import fbb_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        slow_i,
  input  wire logic        reg_req_i,
  input  wire logic        reg_write_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic             reg_done_o,
  output logic             reg_err_o,
  output logic      [15:0] reg_rdata_o
);
  logic [15:0] mem_q [16];
  logic [15:0] data_q;
  logic [2:0]  wait_q;
  logic        act_q, done_q, err_q, hit;
  // only registers 0x01F0..0x01FF and the remote word exist, the rest errors
  assign hit = reg_addr_i[15:4] == 12'h01F || reg_addr_i == FBB_REG_REMOTE;
  assign reg_done_o = done_q;
  assign reg_err_o = done_q & err_q;
  // no stale data between answers
  assign reg_rdata_o = done_q ? data_q : ~data_q;
  always_ff @(posedge clock_i) begin
    done_q <= 1'b0;
    if (!rstn_i) begin
      act_q <= 1'b0;
    end else if (reg_req_i) begin
      act_q  <= 1'b1;
      wait_q <= slow_i ? 3'h4 : 3'h0;
    end else if (act_q && wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end else if (act_q) begin
      act_q  <= 1'b0;
      done_q <= 1'b1;
      err_q  <= !hit;
      data_q <= mem_q[reg_addr_i[3:0]];
      if (reg_write_i && hit) mem_q[reg_addr_i[3:0]] <= reg_wdata_i;
    end
  end
endmodule

// ===== verification/fbb_bridge_tb_top.sv
/* self-checking bench of fbb_bridge with a register space model.
   assumes inputs are driven just after each rising edge. */
`timescale 1ns/1ps
module fbb_bridge_tb_top import fbb_pkg::*; ;
  logic clock_i = 1'b0, rstn_i, bidir_i, res_feature_i, online_i, out_img_valid_i;
  logic svc_req_i, svc_write_i, slow_sel, reg_done_i, reg_err_i, er, in_img_valid_o;
  logic remote_req_o, svc_busy_o, svc_ack_o, svc_err_o, reg_req_o, reg_write_o;
  logic [15:0] out_voltage_i, out_current_i, out_power_i, out_resistance_i, out_sink_current_i;
  logic [15:0] out_sink_power_i, out_sink_res_i, voltage_mon_i, current_mon_i, svc_index_i;
  logic [15:0] svc_wdata_i, in_voltage_mon_o, in_current_mon_o, voltage_setpoint_o, rd;
  logic [15:0] current_setpoint_o, power_setpoint_o, resistance_setpoint_o, svc_index_o;
  logic [15:0] sink_current_setpoint_o, sink_power_setpoint_o, sink_resistance_setpoint_o;
  logic [15:0] svc_rdata_o, reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic [31:0] out_control_i, status_word_i, in_status_o, in_control_o;
  int          n_mismatch = 0, n_checks = 0;
  always #10 clock_i = ~clock_i;
  fbb_bridge dut (.*);
  fbb_regspace_model part (.clock_i(clock_i), .rstn_i(rstn_i), .slow_i(slow_sel),
    .reg_req_i(reg_req_o), .reg_write_i(reg_write_o), .reg_addr_i(reg_addr_o),
    .reg_wdata_i(reg_wdata_o), .reg_done_o(reg_done_i), .reg_err_o(reg_err_i),
    .reg_rdata_o(reg_rdata_i));
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // valid stays high so images can follow back to back
  task automatic image(input logic [15:0] b);
    {out_voltage_i, out_current_i, out_power_i} <= {b, b + 16'h1, b + 16'h2};
    {out_resistance_i, out_sink_current_i} <= {b + 16'h3, b + 16'h4};
    {out_sink_power_i, out_sink_res_i, out_img_valid_i} <= {b + 16'h5, b + 16'h6, 1'b1};
    tick;
  endtask
  task automatic svc(input logic w, input logic [15:0] idx, input logic [15:0] d);
    int k;
    {svc_req_i, svc_write_i, svc_index_i, svc_wdata_i} <= {1'b1, w, idx, d};
    tick;
    svc_req_i <= 1'b0;
    if (online_i === 1'b1) chk("busy", 1'b1, svc_busy_o);
    for (k = 0; k < 40 && svc_ack_o !== 1'b1 && svc_err_o !== 1'b1; k++) tick;
    if (k == 40) begin
      n_mismatch++;
      complete_run;
    end
    rd = svc_rdata_o;
    er = svc_err_o;
    chk("svc_index", idx, svc_index_o);
    tick;
    chk("busy", 1'b0, svc_busy_o);
  endtask
  task automatic t_cyclic;
    {bidir_i, res_feature_i} <= 2'b11;
    image(16'h1000);
    chk("u", 16'h1000, voltage_setpoint_o);
    {bidir_i, res_feature_i} <= 2'b00;
    image(FBB_FULL_SCALE);
    chk("u", FBB_FULL_SCALE, voltage_setpoint_o);
    chk("si", 16'h1004, sink_current_setpoint_o);
    {bidir_i, res_feature_i} <= 2'b10;
    image(16'h2000);
    out_img_valid_i <= 1'b0;
    chk("i", 16'h2001, current_setpoint_o);
    chk("p", 16'h2002, power_setpoint_o);
    chk("r", 16'h1003, resistance_setpoint_o);
    chk("si", 16'h2004, sink_current_setpoint_o);
    chk("sp", 16'h2005, sink_power_setpoint_o);
    chk("sr", 16'h1006, sink_resistance_setpoint_o);
  endtask
  task automatic t_image;
    {status_word_i, out_control_i} <= {32'hA5C3_0F01, 32'h1234_5678};
    {voltage_mon_i, current_mon_i} <= {FBB_FULL_SCALE, 16'h3333};
    tick;
    chk("stat", 32'hA5C3_0F01, in_status_o);
    chk("vmon", FBB_FULL_SCALE, in_voltage_mon_o);
    chk("imon", 16'h3333, in_current_mon_o);
    chk("ctrl", 32'h1234_5678, in_control_o);
    chk("img", 1'b1, in_img_valid_o);
  endtask
  task automatic t_reset;
    rstn_i <= 1'b0;
    repeat (2) tick;
    chk("i", 16'h0000, current_setpoint_o);
    chk("busy", 1'b0, svc_busy_o);
    chk("img", 1'b0, in_img_valid_o);
    rstn_i <= 1'b1;
    tick;
    chk("u", 16'h0000, voltage_setpoint_o);
  endtask
  task automatic t_service;
    svc(1'b1, 16'h21F6, 16'h2A2A);
    chk("err", 1'b0, er);
    chk("i", 16'h2A2A, current_setpoint_o);
    slow_sel <= 1'b1;
    svc(1'b0, 16'h21F6, 16'h0000);
    slow_sel <= 1'b0;
    chk("rdata", 16'h2A2A, rd);
    svc(1'b0, 16'h2001, 16'h0000);
    chk("err", 1'b1, er);
  endtask
  task automatic t_remote;
    svc(1'b1, 16'h2193, FBB_REMOTE_ON);
    chk("remote", 1'b1, remote_req_o);
    image(16'h0000);
    out_img_valid_i <= 1'b0;
    chk("remote", 1'b1, remote_req_o);
    svc(1'b1, 16'h2193, FBB_REMOTE_OFF);
    chk("remote", 1'b0, remote_req_o);
  endtask
  task automatic t_offline;
    online_i <= 1'b0;
    tick;
    svc(1'b0, 16'h21FA, 16'h0000);
    chk("err", 1'b1, er);
    chk("img", 1'b0, in_img_valid_o);
  endtask
  initial begin
    {rstn_i, bidir_i, res_feature_i, online_i, out_img_valid_i, svc_req_i} = 6'h00;
    {svc_write_i, slow_sel, out_control_i, status_word_i} = 66'h0;
    {out_voltage_i, out_current_i, out_power_i, out_resistance_i} = 64'h0;
    {out_sink_current_i, out_sink_power_i, out_sink_res_i, voltage_mon_i} = 64'h0;
    {current_mon_i, svc_index_i, svc_wdata_i} = 48'h0;
    repeat (10) tick;
    rstn_i <= 1'b1;
    online_i <= 1'b1;
    tick;
    chk("u", 16'h0000, voltage_setpoint_o);
    t_cyclic;
    t_image;
    t_service;
    t_reset;
    t_remote;
    t_offline;
    complete_run;
  end
endmodule
bind fbb_bridge fbb_bridge_assertions chk_i (.*);
